// ---- hdl/cra_cfg.svh ----
// constants of the configuration message engine
`ifndef CRA_CFG_SVH
`define CRA_CFG_SVH
`define CRA_TOK_WR 8'hc0
`define CRA_TOK_RD 8'hc1
`define CRA_TOK_PWR 8'h24
`define CRA_TOK_PRD 8'h25
`define CRA_TOK_ACK 8'h03
`define CRA_TOK_NAK 8'h04
`define CRA_TOK_END 8'h01
`define CRA_SUPPRESS 8'hff
`define CRA_RET_LAST 3'h2
`define CRA_REG_LAST 3'h1
`define CRA_WORD_LAST 3'h3
`define CRA_WORD_BYTES 3'h4
`define CRA_MAX_PBYTES 8'h04
`endif

// ---- hdl/cra_pkg.sv ----
// types of the configuration message engine
package cra_pkg;
	typedef struct packed {
		logic ctrl;
		logic [7:0] val;
	} cra_tok_t;
	typedef struct packed {
		logic write;
		logic periph;
		logic [15:0] addr;
		logic [2:0] size;
		logic [31:0] wdata;
	} cra_acc_t;
	typedef enum logic [8:0] {
		CRA_IDLE = 9'h001,
		CRA_RET = 9'h002,
		CRA_REG = 9'h004,
		CRA_SIZE = 9'h008,
		CRA_DATA = 9'h010,
		CRA_END = 9'h020,
		CRA_SKIP = 9'h040,
		CRA_ACC = 9'h080,
		CRA_SEND = 9'h100
	} cra_state_t;
endpackage

// ---- hdl/cra_shift_acc.sv ----
// byte shift register that builds a field most significant byte first
`timescale 1ns/1ps
module cra_shift_acc #(
	parameter int W = 32
) (
	input wire logic ref_clk, // clock
	input wire logic arst_n, // async reset
	input wire logic clr, // clear field
	input wire logic shift, // take one byte
	input wire logic [7:0] din, // byte in
	output logic [W-1:0] q // field
);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			q <= '0;
		end else if (clr) begin
			q <= '0;
		end else if (shift) begin
			q <= {q[W-9:0], din};
		end
	end
endmodule // cra_shift_acc

// ---- hdl/cra_engine.sv ----
// configuration register message engine
// Overview of operation
// - write with return low byte ff: no reply
// - multi-byte fields travel most significant byte first
// - status instructions move exactly one whole word
// - write: 192, return, reg16, data32, token 1
// - write reply: 3,1 success or 4,1 failure
// - read: 193, return, reg16, token 1
// - read reply: 3, 32-bit data, 1; else 4,1
// - peripheral write: 36, return, reg, size, bytes, 1
// - peripheral read: 37, return, reg, size, 1; reply
`timescale 1ns/1ps
`include "cra_cfg.svh"
module cra_engine import cra_pkg::*; #(
	parameter logic [7:0] MAX_PBYTES = `CRA_MAX_PBYTES
) (
	input wire logic ref_clk, // 25 MHz clock
	input wire logic arst_n, // async reset, active low
	input wire logic in_valid, // request token valid
	input wire cra_tok_t in_tok, // request token
	output logic in_ready, // request token taken
	output logic out_valid, // reply token valid
	output cra_tok_t out_tok, // reply token
	output logic [23:0] out_ret, // reply channel, stands for the reply
	input wire logic out_ready, // reply token taken
	output logic cfg_req, // register access request
	output cra_acc_t cfg_acc, // access fields
	input wire logic cfg_ack, // access done
	input wire logic cfg_ok, // register exists
	input wire logic [31:0] cfg_rdata // read data
);
	// ****************************************
	// state and fields
	// ****************************************
	cra_state_t state_reg, state_next;
	logic wr_reg, wr_next, per_reg, per_next, bad_reg, bad_next, fail_reg, fail_next;
	logic [2:0] cnt_reg, cnt_next, rcnt_reg, rcnt_next;
	logic [7:0] size_reg, size_next;
	logic [31:0] rd_reg, rd_next;
	logic out_valid_reg, out_valid_next;
	cra_tok_t out_tok_reg, out_tok_next;
	logic [23:0] ret_q;
	logic [15:0] reg_q;
	logic [31:0] dat_q;

	wire in_fire = in_valid && in_ready;
	wire is_data = in_fire && !in_tok.ctrl;
	wire is_end = in_fire && in_tok.ctrl && in_tok.val == `CRA_TOK_END;
	wire is_ctl = in_fire && in_tok.ctrl;
	wire suppress = wr_reg && ret_q[7:0] == `CRA_SUPPRESS;
	wire [2:0] nbytes = per_reg ? size_reg[2:0] : `CRA_WORD_BYTES;
	wire [2:0] reg_last = per_reg ? 3'h0 : `CRA_REG_LAST;
	wire [2:0] dat_last = per_reg ? size_reg[2:0] - 3'h1 : `CRA_WORD_LAST;
	wire [5:0] rd_sh = {3'h4 - nbytes, 3'h0};
	wire out_end = out_tok_reg.ctrl && out_tok_reg.val == `CRA_TOK_END;

	// a message cut short by an early end token must not swallow the next header
	assign in_ready = state_reg != CRA_ACC && state_reg != CRA_SEND && !(state_reg == CRA_END && fail_reg);
	assign out_valid = out_valid_reg;
	assign out_tok = out_tok_reg;
	assign out_ret = ret_q;
	assign cfg_req = state_reg == CRA_ACC;
	assign cfg_acc = '{write: wr_reg, periph: per_reg, addr: reg_q, size: nbytes, wdata: dat_q};

	// ****************************************
	// field builders
	// ****************************************
	wire start = state_reg == CRA_IDLE && is_ctl;
	cra_shift_acc #(.W(24)) u_ret (.ref_clk(ref_clk), .arst_n(arst_n), .clr(start),
		.shift(state_reg == CRA_RET && is_data), .din(in_tok.val), .q(ret_q));
	cra_shift_acc #(.W(16)) u_reg (.ref_clk(ref_clk), .arst_n(arst_n), .clr(start),
		.shift(state_reg == CRA_REG && is_data), .din(in_tok.val), .q(reg_q));
	cra_shift_acc #(.W(32)) u_dat (.ref_clk(ref_clk), .arst_n(arst_n), .clr(start),
		.shift(state_reg == CRA_DATA && is_data), .din(in_tok.val), .q(dat_q));

	// ****************************************
	// message sequencer
	// ****************************************
	always_comb begin
		state_next = state_reg;
		wr_next = wr_reg;
		per_next = per_reg;
		bad_next = bad_reg;
		fail_next = fail_reg;
		cnt_next = cnt_reg;
		rcnt_next = rcnt_reg;
		size_next = size_reg;
		rd_next = rd_reg;
		out_valid_next = out_valid_reg;
		out_tok_next = out_tok_reg;
		case (state_reg)
			CRA_IDLE: begin
				if (is_ctl) begin
					wr_next = in_tok.val == `CRA_TOK_WR || in_tok.val == `CRA_TOK_PWR;
					per_next = in_tok.val == `CRA_TOK_PWR || in_tok.val == `CRA_TOK_PRD;
					bad_next = !(in_tok.val == `CRA_TOK_WR || in_tok.val == `CRA_TOK_RD ||
						in_tok.val == `CRA_TOK_PWR || in_tok.val == `CRA_TOK_PRD);
					fail_next = 1'b0;
					cnt_next = 3'h0;
					size_next = 8'h00;
					state_next = CRA_RET;
				end
			end
			CRA_RET: begin
				if (is_data) begin
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == `CRA_RET_LAST) begin
						cnt_next = 3'h0;
						fail_next = bad_reg;
						state_next = bad_reg ? CRA_SKIP : CRA_REG;
					end
				end else if (is_ctl) begin
					fail_next = 1'b1;
					state_next = is_end ? CRA_END : CRA_SKIP;
				end
			end
			CRA_REG: begin
				if (is_data) begin
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == reg_last) begin
						cnt_next = 3'h0;
						if (per_reg) begin
							state_next = CRA_SIZE;
						end else begin
							state_next = wr_reg ? CRA_DATA : CRA_END;
						end
					end
				end else if (is_ctl) begin
					fail_next = 1'b1;
					state_next = is_end ? CRA_END : CRA_SKIP;
				end
			end
			CRA_SIZE: begin
				if (is_data) begin
					size_next = in_tok.val;
					if (in_tok.val > MAX_PBYTES) begin
						fail_next = 1'b1;
						state_next = CRA_SKIP;
					end else begin
						state_next = (wr_reg && in_tok.val != 8'h00) ? CRA_DATA : CRA_END;
					end
				end else if (is_ctl) begin
					fail_next = 1'b1;
					state_next = is_end ? CRA_END : CRA_SKIP;
				end
			end
			CRA_DATA: begin
				if (is_data) begin
					cnt_next = cnt_reg + 3'h1;
					if (cnt_reg == dat_last) begin
						state_next = CRA_END;
					end
				end else if (is_ctl) begin
					fail_next = 1'b1;
					state_next = is_end ? CRA_END : CRA_SKIP;
				end
			end
			CRA_END, CRA_SKIP: begin
				if (state_reg == CRA_END && in_fire && !is_end) begin
					fail_next = 1'b1;
					state_next = CRA_SKIP;
				end else if (is_end || (state_reg == CRA_END && fail_reg)) begin
					if (!fail_reg) begin
						state_next = CRA_ACC;
					end else if (suppress) begin
						state_next = CRA_IDLE;
					end else begin
						out_valid_next = 1'b1;
						out_tok_next = '{ctrl: 1'b1, val: `CRA_TOK_NAK};
						rcnt_next = 3'h0;
						state_next = CRA_SEND;
					end
				end
			end
			CRA_ACC: begin
				if (cfg_ack) begin
					if (suppress) begin
						state_next = CRA_IDLE;
					end else begin
						out_valid_next = 1'b1;
						out_tok_next = '{ctrl: 1'b1, val: cfg_ok ? `CRA_TOK_ACK : `CRA_TOK_NAK};
						rcnt_next = (cfg_ok && !wr_reg) ? nbytes : 3'h0;
						rd_next = cfg_rdata << rd_sh;
						state_next = CRA_SEND;
					end
				end
			end
			CRA_SEND: begin
				if (out_ready) begin
					if (out_end) begin
						out_valid_next = 1'b0;
						state_next = CRA_IDLE;
					end else if (rcnt_reg != 3'h0) begin
						out_tok_next = '{ctrl: 1'b0, val: rd_reg[31:24]};
						rd_next = {rd_reg[23:0], 8'h00};
						rcnt_next = rcnt_reg - 3'h1;
					end else begin
						out_tok_next = '{ctrl: 1'b1, val: `CRA_TOK_END};
					end
				end
			end
			default: begin
				state_next = CRA_IDLE;
				out_valid_next = 1'b0;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg <= CRA_IDLE;
			{wr_reg, per_reg, bad_reg, fail_reg, out_valid_reg} <= 5'h00;
			{cnt_reg, rcnt_reg, size_reg} <= 14'h0000;
			rd_reg <= 32'h0000_0000;
			out_tok_reg <= 9'h000;
		end else begin
			state_reg <= state_next;
			{wr_reg, per_reg, bad_reg, fail_reg, out_valid_reg} <=
				{wr_next, per_next, bad_next, fail_next, out_valid_next};
			{cnt_reg, rcnt_reg, size_reg} <= {cnt_next, rcnt_next, size_next};
			rd_reg <= rd_next;
			out_tok_reg <= out_tok_next;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [2:0] sent_q;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sent_q <= 3'h0;
		end else if (state_reg != CRA_SEND) begin
			sent_q <= 3'h0;
		end else if (out_ready && !out_tok_reg.ctrl) begin
			sent_q <= sent_q + 3'h1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence acc_done_s;
		state_reg == CRA_ACC && cfg_ack;
	endsequence
	sequence rd_head_s;
		state_reg == CRA_IDLE && is_ctl && in_tok.val == `CRA_TOK_RD;
	endsequence
	sequence bad_end_s;
		state_reg == CRA_SKIP && bad_reg && is_end && !suppress;
	endsequence

	suppress_no_reply_a: assert property (acc_done_s and suppress |=> state_reg == CRA_IDLE && !out_valid)
		else $error("suppressed write still answered");
	wr_reply_shape_a: assert property (state_reg == CRA_SEND && wr_reg && out_ready && !out_end
		|=> out_tok.ctrl && out_tok.val == `CRA_TOK_END)
		else $error("write reply not closed by end token");
	rd_reply_len_a: assert property (out_valid && out_end && !wr_reg && !fail_reg && !bad_reg
		&& sent_q != 3'h0 |-> sent_q == nbytes)
		else $error("read reply data length wrong");
	msb_first_a: assert property (state_reg == CRA_SEND && out_ready && !out_end && rcnt_reg != 3'h0
		|=> !out_tok.ctrl && out_tok.val == $past(rd_reg[31:24]))
		else $error("reply byte order wrong");
	rd_header_a: assert property (rd_head_s |=> state_reg == CRA_RET && !wr_reg && !per_reg)
		else $error("read header not decoded");
	bad_token_nak_a: assert property (bad_end_s |=> out_valid && out_tok.val == `CRA_TOK_NAK ##1 !cfg_req)
		else $error("unknown header not failed");
	word_length_a: assert property (state_reg == CRA_DATA && !per_reg && is_data && cnt_reg == 3'h3
		|=> state_reg == CRA_END)
		else $error("tile data word not four bytes");
	periph_size_a: assert property (state_reg == CRA_SIZE && is_data && in_tok.val > MAX_PBYTES
		|=> state_reg == CRA_SKIP && fail_reg)
		else $error("oversize peripheral access accepted");
	periph_rd_cnt_a: assert property (acc_done_s and (cfg_ok && per_reg && !wr_reg && !suppress)
		|=> rcnt_reg == $past(size_reg[2:0]) && out_tok.val == `CRA_TOK_ACK)
		else $error("peripheral read reply count wrong");
endmodule // cra_engine

// ---- bench/cra_reg_target.sv ----
// register target model that answers the engine's access port
`timescale 1ns/1ps
module cra_reg_target import cra_pkg::*; (
	input wire logic ref_clk, // clock
	input wire logic arst_n, // async reset
	input wire logic slow, // answer three cycles late
	input wire logic cfg_req, // access request
	input wire cra_acc_t cfg_acc, // access fields
	output logic cfg_ack, // access done pulse
	output logic cfg_ok, // register exists
	output logic [31:0] cfg_rdata // read data
);
	logic [31:0] mem_reg [16];
	logic [2:0] wait_reg;
	wire logic hit = (cfg_acc.addr < 16'h0010);
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_ack <= 1'b0;
			cfg_ok <= 1'b0;
			cfg_rdata <= 32'h0;
			wait_reg <= 3'h0;
			for (int i = 0; i < 16; i++) mem_reg[i] <= 32'h0;
		end else begin
			cfg_ack <= 1'b0;
			cfg_ok <= 1'b0;
			// data lines invert their last value every cycle except when a read of an existing register loads them
			cfg_rdata <= ~cfg_rdata;
			if (cfg_req && !cfg_ack) begin
				if (wait_reg == (slow ? 3'h3 : 3'h0)) begin
					cfg_ack <= 1'b1;
					cfg_ok <= hit;
					wait_reg <= 3'h0;
					if (hit && !cfg_acc.write) cfg_rdata <= mem_reg[cfg_acc.addr[3:0]];
					if (hit && cfg_acc.write) mem_reg[cfg_acc.addr[3:0]] <= cfg_acc.wdata;
				end else begin
					wait_reg <= wait_reg + 3'h1;
				end
			end
		end
	end
endmodule // cra_reg_target

// ---- bench/cra_engine_tb_top.sv ----
// testbench for the configuration message engine
`timescale 1ns/1ps
`include "cra_cfg.svh"
module cra_engine_tb_top import cra_pkg::*;;
	logic ref_clk, arst_n, in_valid, in_ready, out_valid, out_ready, cfg_req, cfg_ack, cfg_ok, slow;
	cra_tok_t in_tok, out_tok;
	logic [23:0] out_ret;
	cra_acc_t cfg_acc;
	logic [31:0] cfg_rdata;
	int fails = 0;
	int total_checks = 0;
	int cycles = 0;
	// channel-end destinations of the register banks, and one status resource id
	localparam logic [31:0] TILE_DEST = {16'h0001, 16'hc20c};
	localparam logic [31:0] NODE_DEST = {16'h0001, 16'hc30c};
	localparam logic [31:0] PER_DEST = {16'h0001, 8'h03, 8'h02};
	localparam logic [31:0] PS_RSRC = (32'h0000_0005 << 8) | 32'h0000_000b;
	cra_engine i_dut (.ref_clk(ref_clk), .arst_n(arst_n), .in_valid(in_valid), .in_tok(in_tok),
		.in_ready(in_ready), .out_valid(out_valid), .out_tok(out_tok), .out_ret(out_ret),
		.out_ready(out_ready), .cfg_req(cfg_req), .cfg_acc(cfg_acc), .cfg_ack(cfg_ack),
		.cfg_ok(cfg_ok), .cfg_rdata(cfg_rdata));
	cra_reg_target i_tgt (.ref_clk(ref_clk), .arst_n(arst_n), .slow(slow), .cfg_req(cfg_req),
		.cfg_acc(cfg_acc), .cfg_ack(cfg_ack), .cfg_ok(cfg_ok), .cfg_rdata(cfg_rdata));
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			summarize();
		end
	end
	// ********************************
	// compare and transfer tasks
	// ********************************
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic cmp_tok(input cra_tok_t exp, input cra_tok_t got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic cmp_word(input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("ERROR t=%0t exp=%h got=%h", $time, exp, got);
		end
	endtask
	task automatic put(input logic c, input logic [7:0] v);
		int n;
		@(negedge ref_clk);
		in_valid = 1'b1;
		in_tok = '{c, v};
		n = 0;
		while (in_ready !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		@(posedge ref_clk);
	endtask
	// fields go out most significant byte first
	task automatic putn(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) put(1'b0, v[8*i+:8]);
	endtask
	task automatic msg(input logic [7:0] hdr, input logic [23:0] ret, input logic [15:0] rg,
		input logic [31:0] d, input int nd);
		put(1'b1, hdr);
		putn({8'h00, ret}, 3);
		putn({16'h0000, rg}, 2);
		putn(d, nd);
		put(1'b1, `CRA_TOK_END);
		@(negedge ref_clk);
		in_valid = 1'b0;
	endtask
	// slow reader: the first token is taken a cycle after it shows, or two when a NAK is sent with no access; later ones two cycles after
	task automatic rx(input logic c, input logic [7:0] v, input logic [23:0] ret);
		int n;
		n = 0;
		@(negedge ref_clk);
		while (out_valid !== 1'b1 && n < 100) begin
			@(negedge ref_clk);
			n++;
		end
		cmp_tok('{c, v}, out_tok);
		cmp_word({8'h00, ret}, {8'h00, out_ret});
		out_ready = 1'b1;
		@(posedge ref_clk);
		@(negedge ref_clk);
		out_ready = 1'b0;
	endtask
	task automatic reply(input logic [23:0] ret, input logic ok, input logic [31:0] d, input int nd);
		rx(1'b1, ok ? `CRA_TOK_ACK : `CRA_TOK_NAK, ret);
		for (int i = nd - 1; i >= 0; i--) rx(1'b0, d[8*i+:8], ret);
		rx(1'b1, `CRA_TOK_END, ret);
	endtask
	task automatic quiet();
		repeat (30) @(negedge ref_clk) cmp_word(32'h0, {31'h0, out_valid});
		cmp_word(32'h1, {31'h0, in_ready});
	endtask
	// ********************************
	// scenarios
	// ********************************
	task automatic t_tile();
		cmp_word(32'h0000_c20c, TILE_DEST & 32'h0000_ffff);
		cmp_word(32'h0000_c30c, NODE_DEST & 32'h0000_ffff);
		cmp_word(32'h0000_050b, PS_RSRC);
		msg(`CRA_TOK_WR, 24'h123456, 16'h0005, 32'ha1b2c3d4, 4);
		reply(24'h123456, 1'b1, 32'h0, 0);
		slow = 1'b1;
		msg(`CRA_TOK_RD, 24'h654321, 16'h0005, 32'h0, 0);
		reply(24'h654321, 1'b1, 32'ha1b2c3d4, 4);
		slow = 1'b0;
	endtask
	task automatic t_suppress();
		msg(`CRA_TOK_WR, 24'h1234ff, 16'h0007, 32'h0badcafe, 4);
		quiet();
		msg(`CRA_TOK_WR, 24'h1234ff, 16'h0100, 32'h1, 4);
		quiet();
		msg(`CRA_TOK_RD, 24'h1234ff, 16'h0007, 32'h0, 0);
		reply(24'h1234ff, 1'b1, 32'h0badcafe, 4);
	endtask
	task automatic t_fail();
		msg(`CRA_TOK_WR, 24'h0a0b0c, 16'h0100, 32'h1, 4);
		reply(24'h0a0b0c, 1'b0, 32'h0, 0);
		msg(`CRA_TOK_RD, 24'h0a0b0c, 16'h0010, 32'h0, 0);
		reply(24'h0a0b0c, 1'b0, 32'h0, 0);
		msg(8'h55, 24'h0a0b0c, 16'h0000, 32'h0, 0);
		reply(24'h0a0b0c, 1'b0, 32'h0, 0);
	endtask
	task automatic t_periph();
		cmp_word(32'h0000_0002, PER_DEST & 32'h0000_00ff);
		msg(`CRA_TOK_PWR, 24'h0c0d0e, 16'h0302, 32'hbeef, 2);
		reply(24'h0c0d0e, 1'b1, 32'h0, 0);
		msg(`CRA_TOK_PRD, 24'h0c0d0e, 16'h0302, 32'h0, 0);
		reply(24'h0c0d0e, 1'b1, 32'hbeef, 2);
		msg(`CRA_TOK_PRD, 24'h0c0d0e, 16'h0305, 32'h0, 0);
		reply(24'h0c0d0e, 1'b0, 32'h0, 0);
	endtask
	initial begin
		arst_n = 1'b0;
		in_valid = 1'b0;
		in_tok = '{1'b0, 8'h00};
		out_ready = 1'b0;
		slow = 1'b0;
		repeat (16) @(negedge ref_clk);
		cmp_word(32'h1, {31'h0, in_ready});
		cmp_word(32'h0, {31'h0, out_valid});
		cmp_word(32'h0, {31'h0, cfg_req});
		arst_n = 1'b1;
		t_tile();
		t_suppress();
		t_fail();
		t_periph();
		summarize();
	end
endmodule // cra_engine_tb_top
